// ===== memmap_pkg.sv
// shared constants and carriers for the address-space control block
package memmap_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned PROG_W = 20;
  localparam int unsigned PAGE_W = 4;
  localparam int unsigned WAIT_W = 4;

  // memory-mapped register addresses in data space
  localparam logic [15:0] ADDR_PAGE_SEL = 16'h001E;
  localparam logic [15:0] ADDR_WAIT_RNG = 16'h0028;
  localparam logic [15:0] ADDR_WAIT_CTL = 16'h002B;
  // mode register address picked for this block
  localparam logic [15:0] ADDR_MODE_REG = 16'h001D;

  // reset values
  localparam logic [15:0] WAIT_RNG_RESET = 16'h7FFF;
  localparam logic [8:0]  VEC_PTR_RESET  = 9'h1FF;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 4'h0;
  localparam logic [15:0] BOOT_ENTRY     = 16'hFF80;

  // processor mode register fields
  localparam int unsigned PM_VEC_LSB   = 7;
  localparam int unsigned PM_BOOT      = 6;
  localparam int unsigned PM_RAM_OVERLAY      = 5;
  localparam int unsigned PM_ADDRESS_VISIBILITY      = 4;
  localparam int unsigned PM_DATA_ROM_MAP      = 3;
  localparam int unsigned PM_CLKOUT_DISABLE    = 2;
  localparam int unsigned PM_SATURATE_ON_MULTIPLY      = 1;
  localparam int unsigned PM_SST       = 0;

  // wait range register fields
  localparam int unsigned WR_XPA  = 15;
  localparam int unsigned WR_IO   = 12;
  localparam int unsigned WR_DHI  = 9;
  localparam int unsigned WR_DLO  = 6;
  localparam int unsigned WR_PHI  = 3;
  localparam int unsigned WR_PLO  = 0;

  // on-chip ROM and RAM boundaries
  localparam logic [15:0] ROM_RSV_LO   = 16'hF000;
  localparam logic [15:0] ROM_BOOT_LO  = 16'hF800;
  localparam logic [15:0] ROM_MU_LO    = 16'hFC00;
  localparam logic [15:0] ROM_A_LO     = 16'hFD00;
  localparam logic [15:0] ROM_SINE_LO  = 16'hFE00;
  localparam logic [15:0] ROM_TEST_LO  = 16'hFF00;
  localparam logic [15:0] ROM_VEC_LO   = 16'hFF80;
  localparam logic [15:0] RAM_LO       = 16'h0060;
  localparam logic [15:0] RAM_HI       = 16'h3FFF;
  localparam logic [15:0] RAM_BLOCK_HI = 16'h1FFF;
  localparam logic [15:0] HALF_PAGE    = 16'h8000;

  typedef enum logic [2:0] {
    SP_PROG = 3'b001,
    SP_DATA = 3'b010,
    SP_IO   = 3'b100
  } space_e;

  typedef enum logic [3:0] {
    FLOW_NONE   = 4'b0001,
    FLOW_FAR    = 4'b0010,
    FLOW_VECTOR = 4'b0100,
    FLOW_PMEM   = 4'b1000
  } flow_e;

  typedef enum logic [7:0] {
    ROM_NONE   = 8'b0000_0001,
    ROM_RSV    = 8'b0000_0010,
    ROM_BOOT   = 8'b0000_0100,
    ROM_MULAW  = 8'b0000_1000,
    ROM_ALAW   = 8'b0001_0000,
    ROM_SINE   = 8'b0010_0000,
    ROM_TEST   = 8'b0100_0000,
    ROM_VECTOR = 8'b1000_0000
  } rom_region_e;

  // one bus request from the core
  typedef struct packed {
    logic              valid;
    space_e            space;
    logic              write;
    logic [PROG_W-1:0] addr;
  } access_s;

  // where a request was steered
  typedef struct packed {
    logic        ram;
    logic        ram_block;
    logic        rom;
    rom_region_e region;
    logic        ext;
  } route_s;

endpackage : memmap_pkg

// ===== wait_counter.sv
// external bus cycle stretcher: programmed waits then ready
`timescale 1ns/100ps
`default_nettype none
module wait_counter #(
  parameter int unsigned W = memmap_pkg::WAIT_W
) (
  input  wire logic         i_clock,
  input  wire logic         i_reset,
  input  wire logic         i_start,
  input  wire logic [W-1:0] i_count,
  input  wire logic         i_ready_sync,
  output logic              o_busy,
  output logic              o_done
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_COUNT = 3'b010,
    ST_READY = 3'b100
  } wait_state_e;

  wait_state_e  state_q;
  logic [W-1:0] cnt_q;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      o_done  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (i_start) begin
            cnt_q   <= i_count;
            state_q <= (i_count == '0) ? ST_READY : ST_COUNT;
          end
        end
        ST_COUNT: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == W'(1)) begin
            state_q <= ST_READY;
          end
        end
        ST_READY: begin
          if (i_ready_sync) begin
            o_done  <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign o_busy = (state_q != ST_IDLE);

  property p_ready_hold;
    @(posedge i_clock) disable iff (i_reset)
      (state_q == ST_READY && !i_ready_sync) |=> !o_done;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("done without ready");

endmodule : wait_counter
`default_nettype wire

// ===== memory_map_paging_waitstates.sv
// address decode, program paging, vector relocation and wait-state control
`timescale 1ns/100ps
`default_nettype none
// How it works
// - boot pin low starts fetch at FF80h
// - decode ROM regions bootloader, tables, vectors
// - FF00h-FF7Fh kept reserved for test
// - two independent 8K dual-access RAM blocks
// - RAM in data 0060h-3FFFh, program when overlay
// - four words per vector entry
// - vector base follows vector page pointer
// - reset sets vector pointer to all ones
// - mode register layout, bits 4-2 read only
// - page register at 001Eh, reset zero
// - twenty-bit program address, sixteen pages
// - far flow instructions load page register
// - program read/write use 20-bit accumulator
// - other flow leaves page register unchanged
// - overlay puts RAM in low 16K every page
// - at most fourteen waits, ready extends more
// - all-zero waits gate generator clock off
// - five 3-bit base counts in low bits
// - multiplier bit doubles base counts
// - reset gives seven waits everywhere
// - wait register at 0028h, layout and resets
// - data halves and I/O range selection
// - extended-range bit merges program counts
// - multiplier at 002Bh bit 0, reset zero
module memory_map_paging_waitstates #(
  parameter int unsigned PAGE_W = memmap_pkg::PAGE_W,
  parameter int unsigned PROG_W = memmap_pkg::PROG_W
) (
  input  wire logic                   i_clock,
  input  wire logic                   i_reset,
  input  wire logic                   i_boot_source_select,
  input  wire logic                   i_ready,
  input  wire memmap_pkg::access_s    i_access,
  input  wire memmap_pkg::flow_e      i_flow,
  input  wire logic [PROG_W-1:0]      i_far_target,
  input  wire logic [6:0]             i_vector_num,
  input  wire logic                   i_reg_write,
  input  wire logic [15:0]            i_reg_addr,
  input  wire logic [15:0]            i_reg_wdata,
  input  wire logic                   i_address_visibility,
  input  wire logic                   i_data_rom_map,
  input  wire logic                   i_clkout_disable,
  output logic [15:0]                 o_reg_rdata,
  output logic [PROG_W-1:0]           o_fetch_addr,
  output logic                        o_fetch_load,
  output memmap_pkg::route_s          o_route,
  output logic [PROG_W-1:0]           o_ext_addr,
  output logic                        o_ext_strobe,
  output logic                        o_stall,
  output logic                        o_access_done,
  output logic                        o_wait_clk_en,
  output logic [PAGE_W-1:0]           o_program_page
);

  // =====================================================================
  // functions
  // =====================================================================
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic [3:0] scale(input logic [2:0] base, input logic mul);
    scale = mul ? {base, 1'b0} : {1'b0, base};
  endfunction : scale

  // =====================================================================
  // input synchronisers
  // =====================================================================
  logic boot_meta_q, boot_sync_q, ready_meta_q, ready_sync_q;
  // boot strap sync runs through reset so the pin is settled at release
  always_ff @(posedge i_clock) begin
    boot_meta_q <= i_boot_source_select;
    boot_sync_q <= boot_meta_q;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ready_meta_q <= 1'b0;
      ready_sync_q <= 1'b0;
    end else begin
      ready_meta_q <= i_ready;
      ready_sync_q <= ready_meta_q;
    end
  end

  // =====================================================================
  // registers
  // =====================================================================
  logic [8:0]        vec_ptr_q;
  logic              boot_q, ram_overlay_q, saturate_on_multiply_q, sst_q;
  logic [PAGE_W-1:0] page_q;
  logic [15:0]       wait_rng_q;
  logic              wait_mul_q;
  logic              reset_seen_q;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      vec_ptr_q <= memmap_pkg::VEC_PTR_RESET;
      ram_overlay_q    <= 1'b0;
      saturate_on_multiply_q    <= 1'b0;
      sst_q     <= 1'b0;
    end else if (i_reg_write && i_reg_addr == memmap_pkg::ADDR_MODE_REG) begin
      vec_ptr_q <= i_reg_wdata[15:memmap_pkg::PM_VEC_LSB];
      ram_overlay_q    <= i_reg_wdata[memmap_pkg::PM_RAM_OVERLAY];
      saturate_on_multiply_q    <= i_reg_wdata[memmap_pkg::PM_SATURATE_ON_MULTIPLY];
      sst_q     <= i_reg_wdata[memmap_pkg::PM_SST];
    end
  end

  // boot strap caught after release, then software may rewrite it
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      reset_seen_q <= 1'b1;
      boot_q       <= 1'b0;
    end else begin
      reset_seen_q <= 1'b0;
      if (reset_seen_q) begin
        boot_q <= boot_sync_q;
      end else if (i_reg_write && i_reg_addr == memmap_pkg::ADDR_MODE_REG) begin
        boot_q <= i_reg_wdata[memmap_pkg::PM_BOOT];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      page_q <= memmap_pkg::PAGE_RESET;
    end else if (i_flow == memmap_pkg::FLOW_FAR) begin
      page_q <= i_far_target[PROG_W-1 -: PAGE_W];
    end else if (i_reg_write && i_reg_addr == memmap_pkg::ADDR_PAGE_SEL) begin
      page_q <= i_reg_wdata[PAGE_W-1:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wait_rng_q <= memmap_pkg::WAIT_RNG_RESET;
    end else if (i_reg_write && i_reg_addr == memmap_pkg::ADDR_WAIT_RNG) begin
      wait_rng_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wait_mul_q <= 1'b0;
    end else if (i_reg_write && i_reg_addr == memmap_pkg::ADDR_WAIT_CTL) begin
      wait_mul_q <= i_reg_wdata[0];
    end
  end

  // register readback; unmapped reads zero
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_reg_rdata <= '0;
    end else if (i_reg_addr == memmap_pkg::ADDR_MODE_REG) begin
      o_reg_rdata <= {vec_ptr_q, boot_q, ram_overlay_q, i_address_visibility,
                      i_data_rom_map, i_clkout_disable, saturate_on_multiply_q, sst_q};
    end else if (i_reg_addr == memmap_pkg::ADDR_PAGE_SEL) begin
      o_reg_rdata <= 16'(page_q);
    end else if (i_reg_addr == memmap_pkg::ADDR_WAIT_RNG) begin
      o_reg_rdata <= wait_rng_q;
    end else if (i_reg_addr == memmap_pkg::ADDR_WAIT_CTL) begin
      o_reg_rdata <= {15'h0000, wait_mul_q};
    end else begin
      o_reg_rdata <= '0;
    end
  end

  // =====================================================================
  // fetch address generation
  // =====================================================================
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_fetch_addr <= '0;
      o_fetch_load <= 1'b0;
    end else if (reset_seen_q) begin
      o_fetch_addr <= {{PAGE_W{1'b0}}, memmap_pkg::BOOT_ENTRY};
      o_fetch_load <= 1'b1;
    end else if (i_flow == memmap_pkg::FLOW_VECTOR) begin
      o_fetch_addr <= {page_q, vec_ptr_q, i_vector_num[4:0], 2'b00};
      o_fetch_load <= 1'b1;
    end else if (i_flow == memmap_pkg::FLOW_FAR) begin
      o_fetch_addr <= i_far_target;
      o_fetch_load <= 1'b1;
    end else begin
      o_fetch_load <= 1'b0;
    end
  end

  // =====================================================================
  // address decode
  // =====================================================================
  logic [15:0] low16;
  logic [PAGE_W-1:0] acc_page;
  memmap_pkg::route_s route_d;
  assign low16 = i_access.addr[15:0];
  // program read/write carry full page, others use current page
  assign acc_page = (i_flow == memmap_pkg::FLOW_PMEM) ?
                    i_access.addr[PROG_W-1 -: PAGE_W] : page_q;

  always_comb begin
    route_d        = '0;
    route_d.region = memmap_pkg::ROM_NONE;
    if (i_access.space == memmap_pkg::SP_DATA &&
        in_range(low16, memmap_pkg::RAM_LO, memmap_pkg::RAM_HI)) begin
      route_d.ram = 1'b1;
    end else if (i_access.space == memmap_pkg::SP_PROG && ram_overlay_q &&
                 in_range(low16, 16'h0000, memmap_pkg::RAM_HI)) begin
      route_d.ram = 1'b1;
    end else if (i_access.space == memmap_pkg::SP_PROG && !boot_q &&
                 acc_page == '0 && low16 >= memmap_pkg::ROM_RSV_LO) begin
      route_d.rom = 1'b1;
      if (low16 >= memmap_pkg::ROM_VEC_LO)       route_d.region = memmap_pkg::ROM_VECTOR;
      else if (low16 >= memmap_pkg::ROM_TEST_LO) route_d.region = memmap_pkg::ROM_TEST;
      else if (low16 >= memmap_pkg::ROM_SINE_LO) route_d.region = memmap_pkg::ROM_SINE;
      else if (low16 >= memmap_pkg::ROM_A_LO)    route_d.region = memmap_pkg::ROM_ALAW;
      else if (low16 >= memmap_pkg::ROM_MU_LO)   route_d.region = memmap_pkg::ROM_MULAW;
      else if (low16 >= memmap_pkg::ROM_BOOT_LO) route_d.region = memmap_pkg::ROM_BOOT;
      else                                       route_d.region = memmap_pkg::ROM_RSV;
    end else begin
      route_d.ext = 1'b1;
    end
    // block select on address bit 13
    route_d.ram_block = route_d.ram && (low16 > memmap_pkg::RAM_BLOCK_HI);
  end
  // test words decode to the ROM_TEST region with rom set, like the other ROM regions

  // =====================================================================
  // wait-state selection
  // =====================================================================
  logic [3:0] wait_sel;
  logic       all_zero;
  always_comb begin
    if (i_access.space == memmap_pkg::SP_IO) begin
      wait_sel = scale(wait_rng_q[memmap_pkg::WR_IO +: 3], wait_mul_q);
    end else if (i_access.space == memmap_pkg::SP_DATA) begin
      wait_sel = (low16 >= memmap_pkg::HALF_PAGE) ?
                 scale(wait_rng_q[memmap_pkg::WR_DHI +: 3], wait_mul_q) :
                 scale(wait_rng_q[memmap_pkg::WR_DLO +: 3], wait_mul_q);
    end else if (wait_rng_q[memmap_pkg::WR_XPA] || low16 < memmap_pkg::HALF_PAGE) begin
      wait_sel = scale(wait_rng_q[memmap_pkg::WR_PLO +: 3], wait_mul_q);
    end else begin
      wait_sel = scale(wait_rng_q[memmap_pkg::WR_PHI +: 3], wait_mul_q);
    end
  end
  assign all_zero = (wait_rng_q[14:0] == 15'h0000);

  logic wc_busy, wc_done, start;
  assign start = i_access.valid && route_d.ext && !wc_busy && !o_stall;

  wait_counter #(
    .W (memmap_pkg::WAIT_W)
  ) u_wait (
    .i_clock      (i_clock),
    .i_reset      (i_reset),
    .i_start      (start),
    .i_count      (wait_sel),
    .i_ready_sync (ready_sync_q),
    .o_busy       (wc_busy),
    .o_done       (wc_done)
  );

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_route       <= '0;
      o_ext_addr    <= '0;
      o_ext_strobe  <= 1'b0;
      o_stall       <= 1'b0;
      o_access_done <= 1'b0;
      o_wait_clk_en <= 1'b1;
    end else begin
      o_route       <= route_d;
      o_wait_clk_en <= !all_zero;
      o_access_done <= wc_done;
      if (start) begin
        o_ext_addr   <= {acc_page, low16};
        o_ext_strobe <= 1'b1;
        o_stall      <= 1'b1;
      end else if (wc_done) begin
        o_ext_strobe <= 1'b0;
        o_stall      <= 1'b0;
      end
    end
  end

  assign o_program_page = page_q;

  // =====================================================================
  // checks
  // =====================================================================
  sequence s_far_taken;
    i_flow == memmap_pkg::FLOW_FAR;
  endsequence

  property p_far_page;
    @(posedge i_clock) disable iff (i_reset)
      s_far_taken |=> page_q == $past(i_far_target[PROG_W-1 -: PAGE_W]);
  endproperty
  a_far_page: assert property (p_far_page) else $error("far flow page not loaded");

  property p_page_hold;
    @(posedge i_clock) disable iff (i_reset)
      (i_flow != memmap_pkg::FLOW_FAR && !i_reg_write) |=> $stable(page_q);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page changed");

  property p_boot_entry;
    @(posedge i_clock) disable iff (i_reset)
      reset_seen_q |=> o_fetch_addr[15:0] == memmap_pkg::BOOT_ENTRY && o_fetch_load;
  endproperty
  a_boot_entry: assert property (p_boot_entry) else $error("bad boot entry");

  property p_gate;
    @(posedge i_clock) disable iff (i_reset)
      all_zero |=> !o_wait_clk_en;
  endproperty
  a_gate: assert property (p_gate) else $error("wait clock not gated");

  property p_max_wait;
    @(posedge i_clock) disable iff (i_reset)
      wait_sel <= 4'd14;
  endproperty
  a_max_wait: assert property (p_max_wait) else $error("wait above fourteen");

  property p_vec_four;
    @(posedge i_clock) disable iff (i_reset)
      (i_flow == memmap_pkg::FLOW_VECTOR && !reset_seen_q) |=> o_fetch_addr[1:0] == 2'b00
        && o_fetch_addr[15:7] == $past(vec_ptr_q);
  endproperty
  a_vec_four: assert property (p_vec_four) else $error("vector base wrong");

  property p_ram_data;
    @(posedge i_clock) disable iff (i_reset)
      (i_access.space == memmap_pkg::SP_DATA && low16 == memmap_pkg::RAM_LO) |=> o_route.ram;
  endproperty
  a_ram_data: assert property (p_ram_data) else $error("RAM not selected");

  property p_stall_until_done;
    @(posedge i_clock) disable iff (i_reset)
      wc_busy |-> o_stall;
  endproperty
  a_stall_until_done: assert property (p_stall_until_done) else $error("stall dropped");

endmodule : memory_map_paging_waitstates
`default_nettype wire

// ===== ext_device.sv
// external memory model on the bus: answers with ready after a set delay
`timescale 1ns/100ps
`default_nettype none
module ext_device (
  input  wire logic       i_clock,
  input  wire logic       i_strobe,
  input  wire logic [7:0] i_delay,
  output logic            o_ready
);
  logic [7:0] cnt_q;
  always_ff @(posedge i_clock) begin
    cnt_q <= i_strobe ? cnt_q + 8'h01 : 8'h00;
  end
  // slow device holds ready low
  // an idle bus reads as not ready, so no stale ready reaches the sync
  assign o_ready = i_strobe && (cnt_q >= i_delay);
endmodule : ext_device
`default_nettype wire

// ===== memory_map_paging_waitstates_bench.sv
// self-checking bench for address decode, paging and wait states
`timescale 1ns/100ps
`default_nettype none
module memory_map_paging_waitstates_bench;
  logic clk = 1'b0, rst = 1'b1, boot = 1'b0, rw = 1'b0;
  logic [2:0] mode_ro = 3'b101;
  logic [7:0] dly = 8'h00;
  logic ready, fload, estb, stall, done, wclk;
  memmap_pkg::access_s acc = '0;
  memmap_pkg::flow_e flow = memmap_pkg::FLOW_NONE;
  memmap_pkg::route_s route, r;
  logic [19:0] tgt = 20'h0_0000, faddr, eaddr;
  logic [6:0] vec = 7'h00;
  logic [15:0] raddr = 16'h0000, wdata = 16'h0000, rdata;
  logic [3:0] page;
  int fail_count = 0, compares = 0;
  always #25 clk = ~clk;
  memory_map_paging_waitstates dut (.i_clock(clk), .i_reset(rst),
    .i_boot_source_select(boot), .i_ready(ready), .i_access(acc), .i_flow(flow),
    .i_far_target(tgt), .i_vector_num(vec), .i_reg_write(rw), .i_reg_addr(raddr),
    .i_reg_wdata(wdata), .i_address_visibility(mode_ro[2]), .i_data_rom_map(mode_ro[1]),
    .i_clkout_disable(mode_ro[0]), .o_reg_rdata(rdata), .o_fetch_addr(faddr),
    .o_fetch_load(fload), .o_route(route), .o_ext_addr(eaddr), .o_ext_strobe(estb),
    .o_stall(stall), .o_access_done(done), .o_wait_clk_en(wclk), .o_program_page(page));
  ext_device mem (.i_clock(clk), .i_strobe(estb), .i_delay(dly), .o_ready(ready));
  // ==========================================
  // shared tasks
  task automatic check(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    raddr = a;
    wdata = d;
    rw = 1'b1;
    @(negedge clk);
    rw = 1'b0;
    @(negedge clk);
  endtask : reg_wr
  task automatic reg_rd(input logic [15:0] a, input logic [15:0] m, input logic [15:0] e);
    raddr = a;
    @(negedge clk);
    @(negedge clk);
    check("reg read", {4'h0, rdata & m}, {4'h0, e});
  endtask : reg_rd
  // one external cycle; lo..hi bound the cycles until done
  task automatic ext_acc(input memmap_pkg::space_e sp, input logic [19:0] a,
                         input int lo, input int hi);
    int n;
    n = 0;
    acc = '{1'b1, sp, 1'b0, a};
    @(negedge clk);
    acc.valid = 1'b0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check("wait cycles", 20'((n >= lo) && (n <= hi)), 20'h0_0001);
    @(negedge clk);
  endtask : ext_acc
  task automatic route_chk(input memmap_pkg::space_e sp, input logic [19:0] a);
    acc = '{1'b1, sp, 1'b0, a};
    @(negedge clk);
    r = route;
    acc.valid = 1'b0;
    // let any external cycle started by the probe finish first
    for (int k = 0; k < 200 && stall !== 1'b0; k++) @(negedge clk);
    @(negedge clk);
  endtask : route_chk
  task automatic flow_go(input memmap_pkg::flow_e f, input logic [19:0] e);
    int n;
    n = 0;
    flow = f;
    @(negedge clk);
    flow = memmap_pkg::FLOW_NONE;
    while (fload !== 1'b1 && n < 5) begin
      @(negedge clk);
      n++;
    end
    check("fetch addr", faddr, e);
  endtask : flow_go
  // ==========================================
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end
  // ==========================================
  // main sequence
  initial begin
    int n;
    logic [15:0] rom_a [7];
    rom_a = '{16'hf000, 16'hf800, 16'hfc00, 16'hfd00, 16'hfe00, 16'hff00, 16'hff80};
    repeat (5) @(negedge clk);
    rst = 1'b0;
    n = 0;
    while (fload !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    check("boot fetch", faddr, 20'h0_ff80);
    reg_rd(memmap_pkg::ADDR_PAGE_SEL, 16'hffff, 16'h0000);
    reg_rd(memmap_pkg::ADDR_WAIT_RNG, 16'hffff, 16'h7fff);
    reg_rd(memmap_pkg::ADDR_WAIT_CTL, 16'hffff, 16'h0000);
    reg_rd(memmap_pkg::ADDR_MODE_REG, 16'hffdc, 16'hff94);
    for (int i = 0; i < 7; i++) begin
      route_chk(memmap_pkg::SP_PROG, {4'h0, rom_a[i]});
      check("rom region", 20'(r.region), 20'(8'h02 << i));
    end
    route_chk(memmap_pkg::SP_DATA, 20'h0_0060);
    check("ram data", 20'(r.ram), 20'h0_0001);
    check("ram block lo", 20'(r.ram_block), 20'h0_0000);
    route_chk(memmap_pkg::SP_DATA, 20'h0_2000);
    check("ram block hi", 20'(r.ram_block), 20'h0_0001);
    route_chk(memmap_pkg::SP_PROG, 20'h0_0100);
    check("ram prog no ram_overlay", 20'(r.ram), 20'h0_0000);
    reg_wr(memmap_pkg::ADDR_MODE_REG, 16'hffbf);
    reg_rd(memmap_pkg::ADDR_MODE_REG, 16'hffff, 16'hffb7);
    route_chk(memmap_pkg::SP_PROG, 20'h0_0100);
    check("ram prog ram_overlay", 20'(r.ram), 20'h0_0001);
    reg_wr(memmap_pkg::ADDR_MODE_REG, 16'h0100);
    ext_acc(memmap_pkg::SP_DATA, 20'h0_4000, 9, 14);
    reg_wr(memmap_pkg::ADDR_WAIT_CTL, 16'hffff);
    reg_rd(memmap_pkg::ADDR_WAIT_CTL, 16'hffff, 16'h0001);
    ext_acc(memmap_pkg::SP_DATA, 20'h0_4000, 16, 21);
    reg_wr(memmap_pkg::ADDR_WAIT_RNG, 16'h3a80);
    reg_rd(memmap_pkg::ADDR_WAIT_RNG, 16'hffff, 16'h3a80);
    ext_acc(memmap_pkg::SP_DATA, 20'h0_4000, 6, 11);
    ext_acc(memmap_pkg::SP_DATA, 20'h0_8000, 12, 17);
    ext_acc(memmap_pkg::SP_IO, 20'h0_0010, 8, 13);
    reg_wr(memmap_pkg::ADDR_WAIT_CTL, 16'h0000);
    ext_acc(memmap_pkg::SP_DATA, 20'h0_4000, 4, 9);
    dly = 8'd30;
    ext_acc(memmap_pkg::SP_DATA, 20'h0_4000, 30, 40);
    dly = 8'd0;
    reg_wr(memmap_pkg::ADDR_WAIT_RNG, 16'h8039);
    ext_acc(memmap_pkg::SP_PROG, 20'h0_9000, 3, 8);
    reg_wr(memmap_pkg::ADDR_WAIT_RNG, 16'h0039);
    ext_acc(memmap_pkg::SP_PROG, 20'h0_9000, 9, 14);
    reg_wr(memmap_pkg::ADDR_WAIT_RNG, 16'h8000);
    @(negedge clk);
    check("wait clk gated", 20'(wclk), 20'h0_0000);
    ext_acc(memmap_pkg::SP_DATA, 20'h0_4000, 2, 7);
    reg_wr(memmap_pkg::ADDR_WAIT_RNG, 16'h0001);
    @(negedge clk);
    check("wait clk on", 20'(wclk), 20'h0_0001);
    tgt = 20'h3_1234;
    flow_go(memmap_pkg::FLOW_FAR, 20'h3_1234);
    check("page after far", 20'(page), 20'h0_0003);
    vec = 7'h05;
    flow_go(memmap_pkg::FLOW_VECTOR, 20'h3_0114);
    check("page after vector", 20'(page), 20'h0_0003);
    reg_rd(memmap_pkg::ADDR_PAGE_SEL, 16'hffff, 16'h0003);
    flow = memmap_pkg::FLOW_PMEM;
    ext_acc(memmap_pkg::SP_PROG, 20'h5_9000, 2, 7);
    flow = memmap_pkg::FLOW_NONE;
    check("pmem ext addr", eaddr, 20'h5_9000);
    check("page after pmem", 20'(page), 20'h0_0003);
    ext_acc(memmap_pkg::SP_PROG, 20'h0_9000, 2, 7);
    check("ext addr in page", eaddr, 20'h3_9000);
    final_report();
  end
endmodule : memory_map_paging_waitstates_bench
`default_nettype wire
